// *** core/smsq_pkg.sv ***
package smsq_pkg;
   // ********************************************
   // Timing.
   // ********************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int DEAD_TIME_NS = 5_000;
   localparam int DEAD_CYC = (DEAD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int REFRESH_MS = 64;
   localparam int REFRESH_CYC = REFRESH_MS * (CLK_HZ / 1000);
   localparam int BIAS_PULSE_CYC = 100;
   localparam int REF_WIN_CYC = 1000;
   localparam int SYNC_STAGES = 3;
   // ********************************************
   // Register map.
   // ********************************************
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam int CTRL_CHG_EN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam int ST_GOOD_BIT = 0;
   localparam int ST_OV_BIT = 1;
   localparam int ST_UV_BIT = 2;
   localparam int ST_HOT_BIT = 3;
   localparam int ST_BOOST_BIT = 4;
   localparam int ST_STORE_BIT = 5;
   localparam int ST_PRI_BIT = 6;
   localparam int ST_SEC_BIT = 7;
   localparam int ST_REFRESH_BIT = 8;
endpackage : smsq_pkg

// *** core/smsq_sync_if.sv ***
`timescale 1ns/1ps
// Synchronised comparator levels shared between the filter and the core.
interface smsq_sync_if;
   logic [3:0] raw;
   logic [3:0] clean;
   modport filt (input raw, output clean);
   modport core (output raw, input clean);
endinterface : smsq_sync_if

// *** core/smsq_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; a level counts once stages two and three agree.
module smsq_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   smsq_sync_if.filt s
);
   logic [3:0] st1_r;
   logic [3:0] st2_r;
   logic [3:0] st3_r;
   logic [3:0] clean_r;
   wire logic [3:0] agree = ~(st2_r ^ st3_r);

   // ********************************************
   // Sampling chain.
   // ********************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st1_r <= 4'h0;
         st2_r <= 4'h0;
         st3_r <= 4'h0;
         clean_r <= 4'h0;
      end else begin
         st1_r <= s.raw;
         st2_r <= st1_r;
         st3_r <= st2_r;
         clean_r <= (agree & st3_r) | (~agree & clean_r);
      end
   end

   assign s.clean = clean_r;
endmodule : smsq_sync

// *** core/smsq_top.sv ***
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module smsq_top (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Comparators; the good and overvoltage ones are sampled only inside refresh, the rest continuously.
   input wire logic good_rise_cmp_i,
   input wire logic good_fall_cmp_i,
   input wire logic ov_cmp_i,
   input wire logic ov_release_cmp_i,
   input wire logic uv_cmp_i,
   input wire logic uv_hyst_cmp_i,
   input wire logic over_temp_i,
   input wire logic input_above_ref_i,
   input wire logic peak_current_i,
   // Outputs.
   output logic primary_gate_n_o,
   output logic secondary_gate_n_o,
   output logic low_side_on_o,
   output logic store_switch_on_o,
   output logic divider_bias_on_o,
   output logic ref_divider_on_o,
   output logic sample_hold_o,
   output logic battery_good_o
);
   // ********************************************
   // Synchronisers.
   // ********************************************
   smsq_sync_if sif ();
   // The continuously watched levels (temperature, undervoltage, input) pass through the
   // shared synchroniser; the refresh-sampled comparators use the local one below.
   assign sif.raw = {over_temp_i, uv_cmp_i, uv_hyst_cmp_i, input_above_ref_i};

   smsq_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .s(sif.filt)
   );

   wire logic temp_hot = sif.clean[3];
   wire logic uv_low = sif.clean[2];
   wire logic uv_high = sif.clean[1];
   wire logic in_above = sif.clean[0];

   // Local three-flop synchroniser for the sampled comparators and peak current.
   logic [4:0] cs1_r;
   logic [4:0] cs2_r;
   logic [4:0] cs3_r;
   logic [4:0] cmp_r;
   wire logic [4:0] cagree = ~(cs2_r ^ cs3_r);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs1_r <= 5'h00;
         cs2_r <= 5'h00;
         cs3_r <= 5'h00;
         cmp_r <= 5'h00;
      end else begin
         cs1_r <= {peak_current_i, good_rise_cmp_i, good_fall_cmp_i, ov_cmp_i, ov_release_cmp_i};
         cs2_r <= cs1_r;
         cs3_r <= cs2_r;
         cmp_r <= (cagree & cs3_r) | (~cagree & cmp_r);
      end
   end

   wire logic peak_hit = cmp_r[4];
   wire logic good_above = cmp_r[3];
   wire logic good_below_n = cmp_r[2];
   wire logic ov_above = cmp_r[1];
   wire logic ov_release_above = cmp_r[0];

   // ********************************************
   // Register bus.
   // ********************************************
   logic [31:0] ctrl_r;
   logic ack_r;
   logic [31:0] rdat_r;
   wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire logic hit_ctrl = wb_adr_i == smsq_pkg::OFS_CTRL;
   wire logic hit_status = wb_adr_i == smsq_pkg::OFS_STATUS;
   wire logic [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic [31:0] ctrl_wr = (ctrl_r & ~byte_mask) | (wb_dat_i & byte_mask);
   wire logic chg_en = ctrl_r[smsq_pkg::CTRL_CHG_EN_BIT];
   logic [31:0] status_w;

   // Single registered ack one cycle after the request; unmapped addresses read zero and ignore writes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
         ctrl_r <= smsq_pkg::CTRL_RST;
      end else begin
         ack_r <= bus_req;
         if (bus_req && wb_we_i && hit_ctrl) begin
            ctrl_r <= {31'h0000_0000, ctrl_wr[smsq_pkg::CTRL_CHG_EN_BIT]};
         end
         rdat_r <= hit_ctrl ? ctrl_r : (hit_status ? status_w : 32'h0000_0000);
      end
   end

   // ********************************************
   // Reference refresh timer.
   // ********************************************
   typedef enum logic [1:0] {SMSQ_IDLE, SMSQ_BIAS, SMSQ_REF} smsq_ref_t;
   smsq_ref_t ref_st_r;
   logic [31:0] period_cnt_r;
   logic [15:0] phase_cnt_r;
   logic good_held_r;
   logic ov_held_r;
   logic ov_rel_held_r;
   logic good_fall_held_r;
   logic decided_r;
   wire logic period_end = period_cnt_r == 32'(smsq_pkg::REFRESH_CYC - 1);

   // Only the bias pulse and the refresh window draw divider current; outside them the held values rule.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_st_r <= SMSQ_IDLE;
         period_cnt_r <= 32'h0000_0000;
         phase_cnt_r <= 16'h0000;
         good_held_r <= 1'b0;
         good_fall_held_r <= 1'b0;
         ov_held_r <= 1'b0;
         ov_rel_held_r <= 1'b0;
         decided_r <= 1'b0;
      end else begin
         period_cnt_r <= period_end ? 32'h0000_0000 : period_cnt_r + 32'h0000_0001;
         unique case (ref_st_r)
            SMSQ_IDLE: begin
               phase_cnt_r <= 16'h0000;
               if (period_end || !decided_r) begin
                  ref_st_r <= SMSQ_BIAS;
               end
            end
            SMSQ_BIAS: begin
               phase_cnt_r <= phase_cnt_r + 16'h0001;
               if (phase_cnt_r == 16'(smsq_pkg::BIAS_PULSE_CYC - 1)) begin
                  phase_cnt_r <= 16'h0000;
                  ref_st_r <= SMSQ_REF;
               end
            end
            SMSQ_REF: begin
               phase_cnt_r <= phase_cnt_r + 16'h0001;
               if (phase_cnt_r == 16'(smsq_pkg::REF_WIN_CYC - 1)) begin
                  good_held_r <= good_above;
                  good_fall_held_r <= good_below_n;
                  ov_held_r <= ov_above;
                  ov_rel_held_r <= ov_release_above;
                  decided_r <= 1'b1;
                  ref_st_r <= SMSQ_IDLE;
               end
            end
            // The fourth code of the two-bit state is unused; recover to idle.
            default: begin
               ref_st_r <= SMSQ_IDLE;
            end
         endcase
      end
   end

   // ********************************************
   // Hysteretic decisions.
   // ********************************************
   logic good_r;
   logic ov_stop_r;
   logic hot_r;
   logic store_r;

   // Thermal hysteresis is in the sensor; the comparator clears 5 C below trip.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         good_r <= 1'b0;
         ov_stop_r <= 1'b0;
         hot_r <= 1'b0;
         store_r <= 1'b0;
      end else begin
         if (good_held_r) begin
            good_r <= 1'b1;
         end else if (!good_fall_held_r) begin
            good_r <= 1'b0;
         end
         if (ov_held_r) begin
            ov_stop_r <= 1'b1;
         end else if (!ov_rel_held_r) begin
            ov_stop_r <= 1'b0;
         end
         hot_r <= temp_hot;
         if (uv_low) begin
            store_r <= 1'b0;
         end else if (uv_high) begin
            store_r <= 1'b1;
         end
      end
   end

   // ********************************************
   // Boost burst gating.
   // ********************************************
   wire logic boost_ok = chg_en & ~hot_r & ~ov_stop_r & decided_r;
   logic low_side_r;

   // The low side stays on until the peak current limit or a loss of boost_ok ends the pulse.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_side_r <= 1'b0;
      end else if (!boost_ok || peak_hit) begin
         low_side_r <= 1'b0;
      end else if (in_above) begin
         low_side_r <= 1'b1;
      end
   end

   // ********************************************
   // Gate changeover.
   // ********************************************
   typedef enum logic [1:0] {SMSQ_OFF, SMSQ_PRI, SMSQ_SEC, SMSQ_DEAD} smsq_mux_t;
   smsq_mux_t mux_st_r;
   logic [15:0] dead_cnt_r;
   logic target_sec_r;
   logic pri_n_r;
   logic sec_n_r;
   wire logic dead_done = dead_cnt_r == 16'(smsq_pkg::DEAD_CYC - 1);

   // Both gates go high first; the new gate only drops after the dead time.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mux_st_r <= SMSQ_OFF;
         dead_cnt_r <= 16'h0000;
         target_sec_r <= 1'b0;
         pri_n_r <= 1'b1;
         sec_n_r <= 1'b1;
      end else begin
         unique case (mux_st_r)
            SMSQ_OFF: begin
               // The good flag follows its capture one edge later, so wait until it
               // has caught up; otherwise the first choice could pick the wrong gate.
               if (decided_r && good_r == good_held_r) begin
                  target_sec_r <= good_r;
                  dead_cnt_r <= 16'h0000;
                  mux_st_r <= SMSQ_DEAD;
               end
            end
            SMSQ_PRI, SMSQ_SEC: begin
               if (good_r != (mux_st_r == SMSQ_SEC)) begin
                  pri_n_r <= 1'b1;
                  sec_n_r <= 1'b1;
                  target_sec_r <= good_r;
                  dead_cnt_r <= 16'h0000;
                  mux_st_r <= SMSQ_DEAD;
               end
            end
            SMSQ_DEAD: begin
               dead_cnt_r <= dead_cnt_r + 16'h0001;
               if (dead_done) begin
                  pri_n_r <= target_sec_r;
                  sec_n_r <= ~target_sec_r;
                  mux_st_r <= target_sec_r ? SMSQ_SEC : SMSQ_PRI;
               end
            end
         endcase
      end
   end

   // ********************************************
   // Status and outputs.
   // ********************************************
   assign status_w = {23'h000000, ref_st_r != SMSQ_IDLE, sec_n_r, pri_n_r, store_r,
                      low_side_r, hot_r, uv_low, ov_stop_r, good_r};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         divider_bias_on_o <= 1'b0;
         ref_divider_on_o <= 1'b0;
         sample_hold_o <= 1'b0;
      end else begin
         divider_bias_on_o <= ref_st_r == SMSQ_BIAS;
         ref_divider_on_o <= ref_st_r == SMSQ_REF;
         sample_hold_o <= ref_st_r == SMSQ_REF;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   assign primary_gate_n_o = pri_n_r;
   assign secondary_gate_n_o = sec_n_r;
   assign low_side_on_o = low_side_r;
   assign store_switch_on_o = store_r;
   assign battery_good_o = good_r;
endmodule : smsq_top

// *** testbench/smsq_pmos_pair.sv ***
`timescale 1ns/1ps
// ********************************************
// Pair of PMOS rail switches behind the gate outputs.
// ********************************************
module smsq_pmos_pair (
   input wire logic pri_gate_n_i,
   input wire logic sec_gate_n_i,
   output logic [1:0] rail_src_o,
   output logic short_o
);
   // A low gate turns its path on; bit 1 is the store, bit 0 the cell.
   assign rail_src_o = {~sec_gate_n_i, ~pri_gate_n_i};
   // Both paths on would tie the cell straight to the store.
   assign short_o = ~pri_gate_n_i & ~sec_gate_n_i;
endmodule : smsq_pmos_pair

// *** testbench/smsq_top_checker.sv ***
`timescale 1ns/1ps
// ********************************************
// Port checker for the rail multiplexer and sampler.
// ********************************************
module smsq_top_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic peak_current_i,
   input wire logic over_temp_i,
   input wire logic uv_cmp_i,
   input wire logic uv_hyst_cmp_i,
   input wire logic primary_gate_n_o,
   input wire logic secondary_gate_n_o,
   input wire logic low_side_on_o,
   input wire logic store_switch_on_o,
   input wire logic divider_bias_on_o,
   input wire logic ref_divider_on_o,
   input wire logic sample_hold_o,
   input wire logic battery_good_o
);
   localparam int DEAD_MIN = smsq_pkg::DEAD_CYC - 3;
   localparam int DEAD_MAX = smsq_pkg::DEAD_CYC + 8;
   int both_cnt;
   int bias_cnt;
   int win_cnt;
   logic good_q;
   int gap_cnt;
   logic bias_seen;
   // The both-high count restarts on each new decision, so a skipped dead time cannot hide.
   always_ff @(posedge clk_i) begin
      good_q <= battery_good_o;
      both_cnt <= (rst_i || ref_divider_on_o || good_q != battery_good_o
                   || !(primary_gate_n_o && secondary_gate_n_o)) ? 0 : both_cnt + 1;
      bias_cnt <= (rst_i || !divider_bias_on_o) ? 0 : bias_cnt + 1;
      win_cnt <= (rst_i || !ref_divider_on_o) ? 0 : win_cnt + 1;
      // Cycles since the last bias pulse began; the first one after reset is not timed.
      gap_cnt <= (rst_i || (divider_bias_on_o && bias_cnt == 0)) ? 1 : gap_cnt + 1;
      bias_seen <= !rst_i && (bias_seen || divider_bias_on_o);
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_gates_exclusive: assert property (primary_gate_n_o || secondary_gate_n_o)
      else $error("both gates low");
   a_reset_gates_high: assert property (disable iff (1'b0) rst_i |=>
      primary_gate_n_o && secondary_gate_n_o) else $error("gates low after reset");
   a_store_after_gap: assert property ($fell(secondary_gate_n_o) |-> primary_gate_n_o
      && $past(both_cnt) >= DEAD_MIN && $past(both_cnt) <= DEAD_MAX)
      else $error("store gate fell without dead time");
   a_cell_after_gap: assert property ($fell(primary_gate_n_o) |-> secondary_gate_n_o
      && $past(both_cnt) >= DEAD_MIN && $past(both_cnt) <= DEAD_MAX)
      else $error("cell gate fell without dead time");
   a_peak_ends_pulse: assert property (peak_current_i [*8] |-> !low_side_on_o)
      else $error("pulse not ended at peak");
   a_hot_stops_boost: assert property (over_temp_i [*8] |-> !low_side_on_o)
      else $error("switching while hot");
   a_uv_opens_switch: assert property (uv_cmp_i [*8] |-> !store_switch_on_o)
      else $error("store switch closed below undervoltage");
   a_uv_hyst_closes: assert property ((uv_hyst_cmp_i && !uv_cmp_i) [*8] |->
      store_switch_on_o) else $error("store switch open above release");
   a_hold_in_window: assert property (sample_hold_o == ref_divider_on_o)
      else $error("hold outside window");
   a_bias_then_refs: assert property (!(divider_bias_on_o && ref_divider_on_o))
      else $error("bias pulse overlaps window");
   a_bias_pulse_len: assert property (bias_cnt <= smsq_pkg::BIAS_PULSE_CYC)
      else $error("bias pulse too long");
   a_window_len: assert property (win_cnt <= smsq_pkg::REF_WIN_CYC)
      else $error("reference window too long");
   a_refresh_period: assert property (divider_bias_on_o && bias_cnt == 0 && bias_seen |->
      gap_cnt >= smsq_pkg::REFRESH_CYC - 1 && gap_cnt <= smsq_pkg::REFRESH_CYC)
      else $error("refresh period wrong");
   c_store_selected: cover property ($fell(secondary_gate_n_o));
   c_cell_selected: cover property ($fell(primary_gate_n_o));
   c_pulse_ended: cover property ($fell(low_side_on_o));
endmodule : smsq_top_checker

bind smsq_top smsq_top_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .peak_current_i, .over_temp_i, .uv_cmp_i, .uv_hyst_cmp_i, .primary_gate_n_o,
   .secondary_gate_n_o, .low_side_on_o, .store_switch_on_o, .divider_bias_on_o,
   .ref_divider_on_o, .sample_hold_o, .battery_good_o);

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
// ********************************************
// Self-checking bench for the rail multiplexer and sampler.
// ********************************************
module testbench;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic good_rise_cmp_i, good_fall_cmp_i, ov_cmp_i, ov_release_cmp_i, uv_cmp_i;
   logic uv_hyst_cmp_i, over_temp_i, input_above_ref_i, peak_current_i;
   logic primary_gate_n_o, secondary_gate_n_o, low_side_on_o, store_switch_on_o;
   logic divider_bias_on_o, ref_divider_on_o, sample_hold_o, battery_good_o, rail_short;
   logic [1:0] rail_src;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   int n, nb, nr;
   smsq_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .good_rise_cmp_i, .good_fall_cmp_i, .ov_cmp_i,
      .ov_release_cmp_i, .uv_cmp_i, .uv_hyst_cmp_i, .over_temp_i, .input_above_ref_i,
      .peak_current_i, .primary_gate_n_o, .secondary_gate_n_o, .low_side_on_o,
      .store_switch_on_o, .divider_bias_on_o, .ref_divider_on_o, .sample_hold_o,
      .battery_good_o);
   smsq_pmos_pair far (.pri_gate_n_i(primary_gate_n_o), .sec_gate_n_i(secondary_gate_n_o),
      .rail_src_o(rail_src), .short_o(rail_short));
   // Free-running 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Two refreshes and seven bus cycles fit well inside this ceiling.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         close_out();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask : chk
   task close_out();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   // One classic cycle; the request stands until ack is seen at an edge.
   task wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      // Ack is registered, so it is seen one edge after the request is taken.
      chk(k == 2, 1'b1, "bus ack latency");
   endtask : wb
   // Reset with the given comparator levels, then follow refresh and changeover.
   task restart(input logic good, input logic ov);
      good_rise_cmp_i <= good;
      good_fall_cmp_i <= good;
      ov_cmp_i <= ov;
      ov_release_cmp_i <= ov;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk({primary_gate_n_o, secondary_gate_n_o}, 2'b11, "gates after reset");
      n = 0;
      nb = 0;
      nr = 0;
      while (n < 3000 && !(nr > 0 && ref_divider_on_o === 1'b0)) begin
         @(posedge clk_i);
         n++;
         nb += (divider_bias_on_o === 1'b1);
         nr += (ref_divider_on_o === 1'b1);
      end
      chk(nb, smsq_pkg::BIAS_PULSE_CYC, "bias pulse");
      chk(nr, smsq_pkg::REF_WIN_CYC, "reference window");
      chk({primary_gate_n_o, secondary_gate_n_o}, 2'b11, "gates before decision");
      n = 0;
      while (n < 1000 && primary_gate_n_o === 1'b1 && secondary_gate_n_o === 1'b1) begin
         @(posedge clk_i);
         n++;
      end
      chk(n >= smsq_pkg::DEAD_CYC - 3 && n <= smsq_pkg::DEAD_CYC + 8, 1'b1, "dead time");
   endtask : restart
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      {uv_cmp_i, over_temp_i, input_above_ref_i, peak_current_i} = '0;
      {good_rise_cmp_i, good_fall_cmp_i, ov_cmp_i, ov_release_cmp_i} = '0;
      wb_sel_i = 4'hf;
      uv_hyst_cmp_i = 1'b1;
      restart(1'b1, 1'b0);
      chk(battery_good_o, 1'b1, "good flag");
      chk({primary_gate_n_o, secondary_gate_n_o}, 2'b10, "store selected");
      chk(rail_src, 2'b10, "rail on store");
      chk(store_switch_on_o, 1'b1, "store switch");
      input_above_ref_i <= 1'b1;
      wb(1'b0, smsq_pkg::OFS_CTRL, 32'h0, rd);
      chk(rd, smsq_pkg::CTRL_RST, "ctrl reset value");
      wb(1'b1, 4'h8, 32'hffff_ffff, rd);
      wb(1'b0, 4'h8, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      wb(1'b1, smsq_pkg::OFS_CTRL, 32'h0, rd);
      wb(1'b0, smsq_pkg::OFS_CTRL, 32'h0, rd);
      chk(rd, 32'h0, "ctrl write");
      chk(low_side_on_o, 1'b0, "charger disabled");
      wb(1'b1, smsq_pkg::OFS_CTRL, 32'h1, rd);
      repeat (20) @(posedge clk_i);
      chk(low_side_on_o, 1'b1, "burst starts");
      peak_current_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk(low_side_on_o, 1'b0, "pulse ends at peak");
      peak_current_i <= 1'b0;
      over_temp_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk(low_side_on_o, 1'b0, "hot stop");
      uv_cmp_i <= 1'b1;
      uv_hyst_cmp_i <= 1'b0;
      wb(1'b0, smsq_pkg::OFS_STATUS, 32'h0, rd);
      chk(rd[smsq_pkg::ST_HOT_BIT], 1'b1, "hot status");
      repeat (10) @(posedge clk_i);
      chk(store_switch_on_o, 1'b0, "undervoltage opens switch");
      over_temp_i <= 1'b0;
      uv_cmp_i <= 1'b0;
      uv_hyst_cmp_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk(low_side_on_o, 1'b1, "charging resumes");
      chk(store_switch_on_o, 1'b1, "switch recloses");
      restart(1'b0, 1'b1);
      chk({primary_gate_n_o, secondary_gate_n_o}, 2'b01, "cell selected");
      chk(rail_src, 2'b01, "rail on cell");
      repeat (30) @(posedge clk_i);
      chk(low_side_on_o, 1'b0, "overvoltage stop");
      chk(rail_short, 1'b0, "no shoot-through");
      close_out();
   end
endmodule : testbench
